// file: hw/stl_gain_trim.sv
`include "stl_map.svh"
`default_nettype none

module stl_gain_trim #(
	parameter int ADC_WIDTH = 12,
	parameter int TRIM_SHIFT = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADC_WIDTH-1:0] sampleRaw,
	input wire logic sampleValid,
	input wire logic [7:0] trim,
	output logic [ADC_WIDTH-1:0] trimmed,
	output logic trimmedValid
);

	localparam int PW = ADC_WIDTH + 7;

	logic [PW-1:0] product;
	logic [PW-1:0] delta;
	logic [PW:0] raised;
	logic overflow;
	logic underflow;
	logic [ADC_WIDTH-1:0] lowered;
	logic [ADC_WIDTH-1:0] next_trimmed;

	// Gain step is magnitude over two to the TRIM_SHIFT; results saturate, never wrap.
	assign product = PW'(sampleRaw) * PW'(trim[`STL_TRIM_MAG_MSB:0]);
	assign delta = product >> TRIM_SHIFT;
	assign raised = (PW + 1)'(sampleRaw) + (PW + 1)'(delta);
	assign overflow = |raised[PW:ADC_WIDTH];
	assign underflow = delta > PW'(sampleRaw);
	assign lowered = sampleRaw - delta[ADC_WIDTH-1:0];
	assign next_trimmed = trim[`STL_TRIM_SIGN_BIT] ?
		(underflow ? '0 : lowered) :
		(overflow ? '1 : raised[ADC_WIDTH-1:0]);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trimmed <= '0;
			trimmedValid <= 1'b0;
		end else begin
			trimmedValid <= sampleValid;
			if (sampleValid) begin
				trimmed <= next_trimmed;
			end
		end
	end

endmodule

`default_nettype wire

// file: hw/stl_load_line_decode.sv
`include "stl_map.svh"
`default_nettype none

module stl_load_line_decode (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] cfg,
	output logic droopEnable,
	output stl_pkg::stl_droop_t droop
);

	stl_pkg::stl_droop_t tableDroop;

	always_comb begin
		case (cfg[`STL_LL_CODE_MSB:0])
			3'h0: tableDroop = `STL_DROOP_CODE0;
			3'h1: tableDroop = `STL_DROOP_CODE1;
			3'h2: tableDroop = `STL_DROOP_CODE2;
			3'h3: tableDroop = `STL_DROOP_CODE3;
			3'h4: tableDroop = `STL_DROOP_CODE4;
			3'h5: tableDroop = `STL_DROOP_CODE5;
			3'h6: tableDroop = `STL_DROOP_CODE6;
			default: tableDroop = `STL_DROOP_CODE7;
		endcase
	end

	// The regulator sees zero droop whenever the enable is clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			droopEnable <= 1'b0;
			droop <= '0;
		end else begin
			droopEnable <= cfg[`STL_LL_ENABLE_BIT];
			droop <= cfg[`STL_LL_ENABLE_BIT] ? tableDroop : '0;
		end
	end

endmodule

`default_nettype wire

// file: hw/stl_map.svh
`ifndef STL_MAP_SVH
`define STL_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define STL_IDX_LOAD_LINE 6'h36
`define STL_IDX_TRIM_FIRST 6'h38
`define STL_IDX_TRIM_SECOND 6'h39
`define STL_IDX_TRIM_THIRD 6'h3A
`define STL_IDX_DROOP_STATUS 6'h3B

// Reset values.
`define STL_RST_LOAD_LINE 8'h00
`define STL_RST_TRIM 8'h00

// Field positions.
`define STL_LL_ENABLE_BIT 3
`define STL_LL_CODE_MSB 2
`define STL_TRIM_SIGN_BIT 7
`define STL_TRIM_MAG_MSB 6

// Load-line droop per code, in hundredths of a milliohm.
`define STL_DROOP_CODE0 13'h141E
`define STL_DROOP_CODE1 13'h0A28
`define STL_DROOP_CODE2 13'h04E2
`define STL_DROOP_CODE3 13'h0271
`define STL_DROOP_CODE4 13'h012C
`define STL_DROOP_CODE5 13'h0096
`define STL_DROOP_CODE6 13'h0046
`define STL_DROOP_CODE7 13'h0000

`endif

// file: hw/stl_pkg.sv
`default_nettype none

package stl_pkg;

	typedef enum logic [1:0] {
		STL_BUS_IDLE = 2'b01,
		STL_BUS_ANSWER = 2'b10
	} stl_bus_t;

	typedef logic [12:0] stl_droop_t;

endpackage

`default_nettype wire

// file: hw/stl_sense_trim_regs.sv
// Local design decision: register access over Avalon-MM.
`include "stl_map.svh"
`default_nettype none

module stl_sense_trim_regs #(
	parameter int ADC_WIDTH = 12,
	parameter int TRIM_SHIFT = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [ADC_WIDTH-1:0] voltageSenseFirstRaw,
	input wire logic voltageSenseFirstValid,
	input wire logic [ADC_WIDTH-1:0] voltageSenseSecondRaw,
	input wire logic voltageSenseSecondValid,
	input wire logic [ADC_WIDTH-1:0] voltageSenseThirdRaw,
	input wire logic voltageSenseThirdValid,
	output logic [ADC_WIDTH-1:0] voltageSenseFirstTrimmed,
	output logic voltageSenseFirstTrimmedValid,
	output logic [ADC_WIDTH-1:0] voltageSenseSecondTrimmed,
	output logic voltageSenseSecondTrimmedValid,
	output logic [ADC_WIDTH-1:0] voltageSenseThirdTrimmed,
	output logic voltageSenseThirdTrimmedValid,
	output logic loadLineDroopEnable,
	output stl_pkg::stl_droop_t loadLineDroop
);

	stl_pkg::stl_bus_t busState;
	stl_pkg::stl_bus_t next_busState;
	logic busReq;
	logic [5:0] regIndex;
	logic hitLoadLine;
	logic hitTrimFirst;
	logic hitTrimSecond;
	logic hitTrimThird;
	logic hitStatus;
	logic writeDone;
	logic [31:0] readMux;
	logic [7:0] loadLineCfg;
	logic [7:0] trimReg [3];
	logic [ADC_WIDTH-1:0] rawArr [3];
	logic rawValid [3];
	logic [ADC_WIDTH-1:0] trimmedArr [3];
	logic trimmedValidArr [3];
	logic [5:0] trimIndex [3];

	// Address decode and read selection.
	assign busReq = avs_read | avs_write;
	assign regIndex = avs_address[7:2];
	assign hitLoadLine = regIndex == `STL_IDX_LOAD_LINE;
	assign hitTrimFirst = regIndex == `STL_IDX_TRIM_FIRST;
	assign hitTrimSecond = regIndex == `STL_IDX_TRIM_SECOND;
	assign hitTrimThird = regIndex == `STL_IDX_TRIM_THIRD;
	assign hitStatus = regIndex == `STL_IDX_DROOP_STATUS;
	// Writes land only on the edge where the master sees waitrequest low.
	assign writeDone = (busState == stl_pkg::STL_BUS_ANSWER) & avs_write &
		avs_byteenable[0];
	// Unmapped addresses read as zero and swallow writes.
	assign readMux = hitLoadLine ? {24'h000000, loadLineCfg} :
		hitTrimFirst ? {24'h000000, trimReg[0]} :
		hitTrimSecond ? {24'h000000, trimReg[1]} :
		hitTrimThird ? {24'h000000, trimReg[2]} :
		hitStatus ? {18'h00000, loadLineDroopEnable, loadLineDroop} :
		32'h00000000;

	assign trimIndex[0] = `STL_IDX_TRIM_FIRST;
	assign trimIndex[1] = `STL_IDX_TRIM_SECOND;
	assign trimIndex[2] = `STL_IDX_TRIM_THIRD;

	always_comb begin
		case (busState)
			stl_pkg::STL_BUS_IDLE: next_busState = busReq ? stl_pkg::STL_BUS_ANSWER :
				stl_pkg::STL_BUS_IDLE;
			stl_pkg::STL_BUS_ANSWER: next_busState = stl_pkg::STL_BUS_IDLE;
			default: next_busState = stl_pkg::STL_BUS_IDLE;
		endcase
	end

	// One wait cycle per access keeps read data registered at the cost of bus speed.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busState <= stl_pkg::STL_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			busState <= next_busState;
			avs_waitrequest <= next_busState != stl_pkg::STL_BUS_ANSWER;
			if (busState == stl_pkg::STL_BUS_IDLE && avs_read) begin
				avs_readdata <= readMux;
			end
		end
	end

	// Reserved bits 7 to 4 are stored and read back as written.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loadLineCfg <= `STL_RST_LOAD_LINE;
		end else if (writeDone && hitLoadLine) begin
			loadLineCfg <= avs_writedata[7:0];
		end
	end

	stl_load_line_decode u_droop (
		.clk(clk),
		.rst(rst),
		.cfg(loadLineCfg[3:0]),
		.droopEnable(loadLineDroopEnable),
		.droop(loadLineDroop)
	);

	assign rawArr[0] = voltageSenseFirstRaw;
	assign rawArr[1] = voltageSenseSecondRaw;
	assign rawArr[2] = voltageSenseThirdRaw;
	assign rawValid[0] = voltageSenseFirstValid;
	assign rawValid[1] = voltageSenseSecondValid;
	assign rawValid[2] = voltageSenseThirdValid;

	for (genvar g = 0; g < 3; g++) begin : g_chan
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				trimReg[g] <= `STL_RST_TRIM;
			end else if (writeDone && regIndex == trimIndex[g]) begin
				trimReg[g] <= avs_writedata[7:0];
			end
		end

		// A trim written mid-stream applies from the next sample on.
		stl_gain_trim #(
			.ADC_WIDTH(ADC_WIDTH),
			.TRIM_SHIFT(TRIM_SHIFT)
		) u_trim (
			.clk(clk),
			.rst(rst),
			.sampleRaw(rawArr[g]),
			.sampleValid(rawValid[g]),
			.trim(trimReg[g]),
			.trimmed(trimmedArr[g]),
			.trimmedValid(trimmedValidArr[g])
		);
	end

	assign voltageSenseFirstTrimmed = trimmedArr[0];
	assign voltageSenseSecondTrimmed = trimmedArr[1];
	assign voltageSenseThirdTrimmed = trimmedArr[2];
	assign voltageSenseFirstTrimmedValid = trimmedValidArr[0];
	assign voltageSenseSecondTrimmedValid = trimmedValidArr[1];
	assign voltageSenseThirdTrimmedValid = trimmedValidArr[2];

	a_droop_off_disabled: assert property (@(posedge clk) disable iff (rst)
		!loadLineCfg[3] |=> !loadLineDroopEnable && loadLineDroop == 13'h0000)
		else $error("Droop applied while load line disabled.");

	a_droop_code_full: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'h8 |=> loadLineDroop == 13'h141E)
		else $error("Code zero droop is not 51.5 milliohm.");

	a_droop_code_low: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'hE |=> loadLineDroop == 13'h0046 ##1
		($past(loadLineCfg[3:0]) != 4'hF || loadLineDroop == 13'h0000))
		else $error("Low droop codes decode wrongly.");

	a_trim_sign_neg: assert property (@(posedge clk) disable iff (rst)
		voltageSenseFirstValid && trimReg[0][7] |=>
		voltageSenseFirstTrimmed <= $past(voltageSenseFirstRaw))
		else $error("Negative trim raised the reading.");

	a_first_gain_unity: assert property (@(posedge clk) disable iff (rst)
		voltageSenseFirstValid && trimReg[0][6:0] == 7'h00 |=>
		voltageSenseFirstTrimmed == $past(voltageSenseFirstRaw))
		else $error("First channel changed with zero trim.");

	a_second_gain_pos: assert property (@(posedge clk) disable iff (rst)
		voltageSenseSecondValid && !trimReg[1][7] && trimReg[1][6:0] == 7'h7F &&
		voltageSenseSecondRaw == 12'h800 |=> voltageSenseSecondTrimmed == 12'h8FE)
		else $error("Second channel positive trim is wrong.");

	a_third_gain_unity: assert property (@(posedge clk) disable iff (rst)
		voltageSenseThirdValid && trimReg[2][6:0] == 7'h00 |=>
		voltageSenseThirdTrimmed == $past(voltageSenseThirdRaw))
		else $error("Third channel changed with zero trim.");

	a_sample_trim_flow: assert property (@(posedge clk) disable iff (rst)
		voltageSenseFirstValid |=> voltageSenseFirstTrimmedValid)
		else $error("Trimmed sample did not follow a raw sample.");

	a_bus_one_wait: assert property (@(posedge clk) disable iff (rst)
		busReq && busState == stl_pkg::STL_BUS_IDLE |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("Bus answer timing is wrong.");

	a_bus_write_lands: assert property (@(posedge clk) disable iff (rst)
		writeDone && hitLoadLine |=> loadLineCfg == $past(avs_writedata[7:0]))
		else $error("Load line write lost.");

	a_droop_enable_on: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3] |=> loadLineDroopEnable)
		else $error("Droop enable did not follow the load line bit.");

	a_droop_code_one: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'h9 |=> loadLineDroop == 13'h0A28)
		else $error("Code one droop is not 26 milliohm.");

	a_droop_code_two: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'hA |=> loadLineDroop == 13'h04E2)
		else $error("Code two droop is not 12.5 milliohm.");

	a_droop_code_three: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'hB |=> loadLineDroop == 13'h0271)
		else $error("Code three droop is not 6.25 milliohm.");

	a_droop_code_four: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'hC |=> loadLineDroop == 13'h012C)
		else $error("Code four droop is not 3 milliohm.");

	a_droop_code_five: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'hD |=> loadLineDroop == 13'h0096)
		else $error("Code five droop is not 1.5 milliohm.");

	a_droop_code_seven: assert property (@(posedge clk) disable iff (rst)
		loadLineCfg[3:0] == 4'hF |=> loadLineDroopEnable && loadLineDroop == 13'h0000)
		else $error("Code seven droop is not zero.");

	a_first_sign_pos: assert property (@(posedge clk) disable iff (rst)
		voltageSenseFirstValid && !trimReg[0][7] |=>
		voltageSenseFirstTrimmed >= $past(voltageSenseFirstRaw))
		else $error("Positive trim lowered the first reading.");

	a_second_sign_neg: assert property (@(posedge clk) disable iff (rst)
		voltageSenseSecondValid && trimReg[1][7] |=>
		voltageSenseSecondTrimmed <= $past(voltageSenseSecondRaw))
		else $error("Negative trim raised the second reading.");

	a_third_sign_pos: assert property (@(posedge clk) disable iff (rst)
		voltageSenseThirdValid && !trimReg[2][7] |=>
		voltageSenseThirdTrimmed >= $past(voltageSenseThirdRaw))
		else $error("Positive trim lowered the third reading.");

	a_third_sign_neg: assert property (@(posedge clk) disable iff (rst)
		voltageSenseThirdValid && trimReg[2][7] |=>
		voltageSenseThirdTrimmed <= $past(voltageSenseThirdRaw))
		else $error("Negative trim raised the third reading.");

	a_first_gain_full: assert property (@(posedge clk) disable iff (rst)
		voltageSenseFirstValid && trimReg[0] == 8'h7F && voltageSenseFirstRaw == 12'hFFF |=>
		voltageSenseFirstTrimmed == 12'hFFF)
		else $error("First channel positive trim did not saturate.");

	a_first_gain_neg: assert property (@(posedge clk) disable iff (rst)
		voltageSenseFirstValid && trimReg[0] == 8'hFF && voltageSenseFirstRaw == 12'hA53 |=>
		voltageSenseFirstTrimmed == 12'h90C)
		else $error("First channel negative trim is wrong.");

	a_second_gain_unity: assert property (@(posedge clk) disable iff (rst)
		voltageSenseSecondValid && trimReg[1][6:0] == 7'h00 |=>
		voltageSenseSecondTrimmed == $past(voltageSenseSecondRaw))
		else $error("Second channel changed with zero trim.");

	a_second_gain_neg: assert property (@(posedge clk) disable iff (rst)
		voltageSenseSecondValid && trimReg[1] == 8'hFF && voltageSenseSecondRaw == 12'hA5A |=>
		voltageSenseSecondTrimmed == 12'h912)
		else $error("Second channel negative trim is wrong.");

	a_third_gain_neg: assert property (@(posedge clk) disable iff (rst)
		voltageSenseThirdValid && trimReg[2] == 8'h85 && voltageSenseThirdRaw == 12'h5AC |=>
		voltageSenseThirdTrimmed == 12'h5A5)
		else $error("Third channel negative trim is wrong.");

	a_sample_no_spurious: assert property (@(posedge clk) disable iff (rst)
		!voltageSenseFirstValid |=> !voltageSenseFirstTrimmedValid)
		else $error("Trimmed sample appeared without a raw sample.");

	a_second_trim_flow: assert property (@(posedge clk) disable iff (rst)
		voltageSenseSecondValid |=> voltageSenseSecondTrimmedValid)
		else $error("Second trimmed sample did not follow a raw sample.");

	a_third_trim_flow: assert property (@(posedge clk) disable iff (rst)
		voltageSenseThirdValid |=> voltageSenseThirdTrimmedValid)
		else $error("Third trimmed sample did not follow a raw sample.");

	a_trimmed_holds: assert property (@(posedge clk) disable iff (rst)
		!voltageSenseFirstValid |=> $stable(voltageSenseFirstTrimmed))
		else $error("First trimmed value changed without a sample.");

	a_bus_read_data: assert property (@(posedge clk) disable iff (rst)
		busState == stl_pkg::STL_BUS_IDLE && avs_read && hitTrimFirst |=>
		avs_readdata == {24'h000000, $past(trimReg[0])})
		else $error("Read data does not hold the addressed trim.");

	a_bus_wait_idle: assert property (@(posedge clk) disable iff (rst)
		!busReq && busState == stl_pkg::STL_BUS_IDLE |=> avs_waitrequest)
		else $error("Waitrequest dropped with no request.");

	a_trim_write_lands: assert property (@(posedge clk) disable iff (rst)
		writeDone && hitTrimThird |=> trimReg[2] == $past(avs_writedata[7:0]))
		else $error("Third trim write lost.");

	a_byte_mask_blocks: assert property (@(posedge clk) disable iff (rst)
		busState == stl_pkg::STL_BUS_ANSWER && avs_write && !avs_byteenable[0] |=>
		$stable(loadLineCfg) && $stable(trimReg[2]))
		else $error("Write landed with its low byte lane masked.");

endmodule

`default_nettype wire

// file: test/test_stl_sense_trim_regs.sv
`default_nettype none

module test_stl_sense_trim_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic waitReq;
	logic [11:0] raw [3] = '{12'h000, 12'h000, 12'h000};
	logic [2:0] valid = 3'b000;
	logic [11:0] trimmed [3];
	logic [2:0] trimmedValid;
	logic droopEn;
	stl_pkg::stl_droop_t droop;
	int errors = 0;
	int totalChecks = 0;
	int cycles = 0;
	logic [31:0] seen;
	logic [12:0] droopTable [8] = '{13'h141E, 13'h0A28, 13'h04E2, 13'h0271,
		13'h012C, 13'h0096, 13'h0046, 13'h0000};
	logic [7:0] regAddr [5] = '{8'hD8, 8'hE0, 8'hE4, 8'hE8, 8'hEC};
	logic [7:0] trimTable [4] = '{8'h00, 8'h7F, 8'h85, 8'hFF};

	stl_sense_trim_regs i_stl_sense_trim_regs (
		.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(waitReq),
		.voltageSenseFirstRaw(raw[0]), .voltageSenseFirstValid(valid[0]),
		.voltageSenseSecondRaw(raw[1]), .voltageSenseSecondValid(valid[1]),
		.voltageSenseThirdRaw(raw[2]), .voltageSenseThirdValid(valid[2]),
		.voltageSenseFirstTrimmed(trimmed[0]), .voltageSenseFirstTrimmedValid(trimmedValid[0]),
		.voltageSenseSecondTrimmed(trimmed[1]), .voltageSenseSecondTrimmedValid(trimmedValid[1]),
		.voltageSenseThirdTrimmed(trimmed[2]), .voltageSenseThirdTrimmedValid(trimmedValid[2]),
		.loadLineDroopEnable(droopEn), .loadLineDroop(droop)
	);

	always #50 clk = ~clk;

	task automatic close_out;
		if (errors == 0 && totalChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors = errors + 1;
			close_out();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	// The request is held until waitrequest is sampled low, whatever the latency.
	task automatic busDo(input logic isWrite, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= isWrite;
		rd <= !isWrite;
		do @(posedge clk); while (waitReq !== 1'b0);
		seen = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	function automatic logic [11:0] gain(input logic [11:0] r, input logic [7:0] t);
		logic [19:0] d;
		d = (20'(r) * 20'(t[6:0])) >> 10;
		if (t[7]) return (d > 20'(r)) ? 12'h000 : 12'(20'(r) - d);
		return (20'(r) + d > 20'hFFF) ? 12'hFFF : 12'(20'(r) + d);
	endfunction

	// Steps the trim magnitude up until a 1 V reading lands on the target code.
	task automatic calibrate(input int ch, input logic [11:0] r, input logic sign,
		input logic [7:0] expTrim);
		logic [7:0] t;
		logic [11:0] got;
		t = {sign, 7'h00};
		got = 12'h000;
		for (int m = 0; m < 128 && got !== 12'hA53; m++) begin
			t = {sign, 7'(m)};
			busDo(1'b1, regAddr[ch + 1], 32'(t));
			@(posedge clk);
			raw[ch] <= r;
			valid[ch] <= 1'b1;
			@(posedge clk);
			valid[ch] <= 1'b0;
			@(posedge clk);
			got = trimmed[ch];
		end
		check(32'(got), 32'h00000A53);
		check(32'(t), 32'(expTrim));
	endtask

	task automatic sample(input logic [7:0] t0, t1, t2, input logic [11:0] r);
		@(posedge clk);
		raw[0] <= r;
		raw[1] <= r ^ 12'h5A5;
		raw[2] <= ~r;
		valid <= 3'b111;
		@(posedge clk);
		valid <= 3'b000;
		@(posedge clk);
		check(32'(trimmedValid), 32'h7);
		check(32'(trimmed[0]), 32'(gain(r, t0)));
		check(32'(trimmed[1]), 32'(gain(r ^ 12'h5A5, t1)));
		check(32'(trimmed[2]), 32'(gain(~r, t2)));
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			busDo(1'b0, regAddr[i], 32'h0);
			check(seen, 32'h0);
		end
		for (int c = 0; c < 8; c++) begin
			busDo(1'b1, 8'hD8, 32'({4'(c), 1'b1, 3'(c)}));
			busDo(1'b0, 8'hD8, 32'h0);
			check(seen, 32'({4'(c), 1'b1, 3'(c)}));
			busDo(1'b0, 8'hEC, 32'h0);
			check(seen, 32'({1'b1, droopTable[c]}));
			check(32'({droopEn, droop}), 32'({1'b1, droopTable[c]}));
		end
		busDo(1'b1, 8'hD8, 32'h07);
		busDo(1'b0, 8'hEC, 32'h0);
		check(seen, 32'h0);
		check(32'({droopEn, droop}), 32'h0);
		for (int i = 0; i < 4; i++) begin
			busDo(1'b1, 8'hE0, 32'(trimTable[i]));
			busDo(1'b1, 8'hE4, 32'(trimTable[(i + 1) % 4]));
			busDo(1'b1, 8'hE8, 32'(trimTable[(i + 2) % 4]));
			sample(trimTable[i], trimTable[(i + 1) % 4], trimTable[(i + 2) % 4], 12'hFFF);
			sample(trimTable[i], trimTable[(i + 1) % 4], trimTable[(i + 2) % 4], 12'hA53);
			sample(trimTable[i], trimTable[(i + 1) % 4], trimTable[(i + 2) % 4], 12'hDA5);
			busDo(1'b0, 8'hE4, 32'h0);
			check(seen, 32'(trimTable[(i + 1) % 4]));
		end
		be <= 4'hE;
		busDo(1'b1, 8'hE8, 32'h55);
		be <= 4'hF;
		busDo(1'b0, 8'hE8, 32'h0);
		check(seen, 32'(trimTable[1]));
		busDo(1'b1, 8'hDC, 32'hFF);
		busDo(1'b0, 8'hDC, 32'h0);
		check(seen, 32'h0);
		calibrate(0, 12'hA28, 1'b0, 8'h11);
		calibrate(1, 12'hAAA, 1'b1, 8'hA1);
		calibrate(2, 12'hA28, 1'b0, 8'h11);
		close_out();
	end
endmodule

`default_nettype wire
